// File: ems_params.svh
// Purpose: Constants for the external memory strobe and reset pin block
// Assumes: One oscillator period is one osc enable pulse of the core clock
// Notes: Included by bare name; definitions only
// Functional notes
// [RQ1] Outside reset source holds reset pin high two machine cycles to reset device.
// [RQ2] After watchdog timeout the device drives reset pin high for 98 oscillator periods.
// [RQ3] Reset-out disable bit in aux control register suppresses the watchdog pin pulse.
// [RQ4] Reset leaves reset-out disable at default zero, so the pulse stays enabled.
// [RQ5] Address latch strobe pulses during external accesses to capture the low address.
// [RQ6] Address latch strobe normally pulses continuously at one sixth oscillator rate.
// [RQ7] Exactly one address latch strobe pulse is skipped per external data access.
// [RQ8] With bit 0 set, latch strobe only for data or code moves; else weak high.
// [RQ9] The latch strobe disable bit has no effect during external execution.
// [RQ10] During external execution the program fetch strobe fires twice per machine cycle.
// [RQ11] Two program fetch strobes are skipped for each external data memory access.
// [RQ12] Fetch select pin low sends every fetch, 0000H to FFFFH, to external memory.
// [RQ13] With lock bit 1 programmed, fetch select level is latched at reset.
// [RQ14] Board ties fetch select pin high for execution from internal memory.
// [RQ15] Port three pin six is the external data memory write strobe.
// [RQ16] Port three pin seven is the external data memory read strobe.
// [RQ17] One machine cycle is twelve oscillator periods; all strobe rates derive from it.
// [RQ18] Internal reset stays asserted during reset-out and releases after the pin is low.
`ifndef EMS_PARAMS_SVH
`define EMS_PARAMS_SVH

`define EMS_MC_LAST 4'hB
`define EMS_ALE_A_START 4'h0
`define EMS_ALE_A_END 4'h1
`define EMS_ALE_B_START 4'h6
`define EMS_ALE_B_END 4'h7
`define EMS_PROGRAM_FETCH_STROBE_A_START 4'h3
`define EMS_PROGRAM_FETCH_STROBE_A_END 4'h5
`define EMS_PROGRAM_FETCH_STROBE_B_START 4'h9
`define EMS_PROGRAM_FETCH_STROBE_B_END 4'hB
`define EMS_XD1_START 4'hA
`define EMS_XD2_END 4'h5
`define EMS_RST_IN_MC 8'h02
`define EMS_RST_OUT_OSC 8'h62
`define EMS_INT_CODE_TOP 16'h1FFF

`define EMS_IDX_AUX 12'h08E
`define EMS_IDX_STATUS 12'h090
`define EMS_AUX_ALE_DIS_BIT 0
`define EMS_AUX_RTO_DIS_BIT 3
`define EMS_AUX_RESET 8'h00
`define EMS_ST_EXT_EXEC_BIT 0
`define EMS_ST_RTO_BIT 1
`define EMS_ST_CORE_RST_BIT 2
`define EMS_ST_EA_BIT 3
`define EMS_ST_DATA_BIT 4

`endif

// File: ems_pkg.sv
// Purpose: Types for the external memory strobe and reset pin block
// Assumes: Constants live in ems_params.svh
// Notes: Used by scoped name only
package ems_pkg;
    typedef enum logic [1:0] {
        EMS_FETCH,
        EMS_DATA1,
        EMS_DATA2
    } ems_cycle_t;
endpackage

// File: ems_sync2.sv
// Purpose: Two flip-flop synchroniser for pin inputs
// Assumes: Bits are independent levels
// Notes: First stage is read only by the second stage
`timescale 1ns/100ps
`default_nettype none
module ems_sync2 #(
    parameter int W = 1
) (
    input wire logic clk_i, // Clock
    input wire logic rst_i, // Synchronous reset, active high
    input wire logic [W-1:0] d_i, // Asynchronous levels
    output logic [W-1:0] q_o // Synchronised levels
);
    logic [W-1:0] meta_r;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            meta_r <= '0;
            q_o <= '0;
        end else begin
            meta_r <= d_i;
            q_o <= meta_r;
        end
    end
endmodule // ems_sync2
`default_nettype wire

// File: ems_down_counter.sv
// Purpose: Loadable down counter used for reset pulse timing
// Assumes: Load wins over decrement
// Notes: Stops at zero
`timescale 1ns/100ps
`default_nettype none
module ems_down_counter #(
    parameter int W = 8
) (
    input wire logic clk_i, // Clock
    input wire logic rst_i, // Synchronous reset, active high
    input wire logic load_i, // Load start value
    input wire logic [W-1:0] load_val_i, // Start value
    input wire logic dec_i, // Count one step down
    output logic zero_o // Count is zero
);
    logic [W-1:0] cnt_r;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cnt_r <= '0;
        end else if (load_i) begin
            cnt_r <= load_val_i;
        end else if (dec_i && cnt_r != '0) begin
            cnt_r <= cnt_r - 1'b1;
        end
    end

    assign zero_o = (cnt_r == '0);
endmodule // ems_down_counter
`default_nettype wire

// File: ems_strobe_ctrl.sv
// Purpose: Machine cycle timing, address latch, fetch and data strobes, reset pin
// Assumes: Core request inputs are on ref_clk_i; pins are asynchronous
// Notes: Avalon-MM slave with one wait state on every access
`timescale 1ns/100ps
`default_nettype none
`include "ems_params.svh"
module ems_strobe_ctrl #(
    parameter int OSC_DIV = 1, // Core clocks per oscillator period
    parameter int ADDR_W = 12 // Avalon byte address width
) (
    input wire logic ref_clk_i, // 200 MHz clock
    input wire logic sys_rst_i, // Synchronous reset, active high
    input wire logic [ADDR_W-1:0] avs_address_i, // Byte address
    input wire logic avs_read_i, // Read request
    input wire logic avs_write_i, // Write request
    input wire logic [31:0] avs_writedata_i, // Write data
    input wire logic [3:0] avs_byteenable_i, // Byte enables
    output logic [31:0] avs_readdata_o, // Read data, registered
    output logic avs_waitrequest_o, // Stall
    input wire logic [15:0] fetch_addr_i, // Current code fetch address
    input wire logic code_move_instr_i, // Code move instruction executing
    input wire logic xdata_req_i, // External data move request, level
    input wire logic xdata_we_i, // Request is a write
    output logic xdata_done_o, // Data move finished, one pulse
    input wire logic wdt_timeout_i, // Watchdog overflow, one pulse
    input wire logic lock_bit1_i, // Lock bit 1 programmed
    input wire logic external_fetch_select_n_i, // Fetch select pin, low for external
    input wire logic rst_pin_i, // Reset pin level
    output logic rst_pin_o, // Reset pin drive value
    output logic rst_pin_oe_n_o, // Reset pin drive enable, low drives
    output logic ale_o, // Address latch strobe
    output logic ale_oe_n_o, // Latch strobe drive enable, low drives
    output logic program_fetch_strobe_n_o, // Program fetch read strobe
    output logic port_three_pin_six_o, // Data write strobe, active low
    output logic port_three_pin_seven_o, // Data read strobe, active low
    output logic ext_exec_o, // Fetching from external memory
    output logic core_rst_o // Internal reset to the core
);
    // Oscillator period enable and machine cycle phase
    logic [7:0] div_r;
    logic osc_en;
    logic [3:0] phase_r;
    logic mc_end;
    ems_pkg::ems_cycle_t cyc_r, cyc_nxt;
    logic xd_we_r;

    assign osc_en = (div_r == 8'(OSC_DIV - 1));
    assign mc_end = osc_en && (phase_r == `EMS_MC_LAST); // [RQ17]

    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i || osc_en) begin
            div_r <= 8'h00;
        end else begin
            div_r <= div_r + 8'h01;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i || core_rst_o) begin
            phase_r <= 4'h0;
        end else if (mc_end) begin
            phase_r <= 4'h0; // [RQ17]
        end else if (osc_en) begin
            phase_r <= phase_r + 4'h1;
        end
    end

    // Pin synchronisers
    logic [1:0] pin_s;
    logic rst_pin_s;
    logic ea_n_s;

    ems_sync2 #(.W(2)) u_pin_sync (
        .clk_i(ref_clk_i),
        .rst_i(sys_rst_i),
        .d_i({rst_pin_i, external_fetch_select_n_i}),
        .q_o(pin_s)
    );
    assign rst_pin_s = pin_s[1];
    assign ea_n_s = pin_s[0];

    // Registers
    logic [7:0] aux_r;
    logic [31:0] rdata_r;
    logic ack_r;
    logic [ADDR_W-1:0] idx_full;
    logic hit_aux;
    logic hit_status;
    logic aux_wr;
    logic [31:0] status_w;
    logic ale_dis;
    logic rto_dis;

    assign idx_full = avs_address_i >> 2;
    assign hit_aux = (idx_full == ADDR_W'(`EMS_IDX_AUX)) && (avs_address_i[1:0] == 2'b00);
    assign hit_status = (idx_full == ADDR_W'(`EMS_IDX_STATUS)) && (avs_address_i[1:0] == 2'b00);
    // A write lands only at the edge where waitrequest is seen low
    assign aux_wr = avs_write_i && ack_r && hit_aux && avs_byteenable_i[0];
    assign avs_waitrequest_o = (avs_read_i || avs_write_i) && !ack_r;
    assign avs_readdata_o = rdata_r;
    assign ale_dis = aux_r[`EMS_AUX_ALE_DIS_BIT];
    assign rto_dis = aux_r[`EMS_AUX_RTO_DIS_BIT];

    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            ack_r <= 1'b0;
        end else begin
            ack_r <= (avs_read_i || avs_write_i) && !ack_r;
        end
    end

    // Device reset also returns the aux bits to default
    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i || core_rst_o) begin
            aux_r <= `EMS_AUX_RESET; // [RQ4]
        end else if (aux_wr) begin
            aux_r <= avs_writedata_i[7:0];
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            rdata_r <= 32'h0000_0000;
        end else if (avs_read_i && !ack_r) begin
            rdata_r <= hit_aux ? {24'h00_0000, aux_r} :
                       hit_status ? status_w : 32'h0000_0000;
        end
    end

    // Fetch select strap and external execution
    logic ea_lat_r;
    logic [1:0] armed_r;
    logic ea_n_eff;

    // Keep latching until the synchroniser holds the real strap level, not its reset value
    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            ea_lat_r <= 1'b1;
            armed_r <= 2'h0;
        end else begin
            if (armed_r != '1) begin
                armed_r <= armed_r + 2'h1;
            end
            if (core_rst_o || armed_r != '1) begin
                ea_lat_r <= ea_n_s; // [RQ13]
            end
        end
    end

    assign ea_n_eff = lock_bit1_i ? ea_lat_r : ea_n_s; // [RQ13]
    assign ext_exec_o = !ea_n_eff || (fetch_addr_i > `EMS_INT_CODE_TOP); // [RQ12]

    // Bus cycle sequencing: data access spans two machine cycles
    always_comb begin
        cyc_nxt = cyc_r;
        unique case (cyc_r)
            ems_pkg::EMS_FETCH: if (xdata_req_i) cyc_nxt = ems_pkg::EMS_DATA1;
            ems_pkg::EMS_DATA1: cyc_nxt = ems_pkg::EMS_DATA2;
            ems_pkg::EMS_DATA2: cyc_nxt = ems_pkg::EMS_FETCH;
            default: cyc_nxt = ems_pkg::EMS_FETCH;
        endcase
    end

    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i || core_rst_o) begin
            cyc_r <= ems_pkg::EMS_FETCH;
            xd_we_r <= 1'b0;
        end else if (mc_end) begin
            cyc_r <= cyc_nxt;
            if (cyc_r == ems_pkg::EMS_FETCH) begin
                xd_we_r <= xdata_we_i;
            end
        end
    end

    assign xdata_done_o = mc_end && (cyc_r == ems_pkg::EMS_DATA2);

    // Strobe generation
    logic in_data;
    logic ale_slot;
    logic program_fetch_strobe_slot;
    logic xd_slot;
    logic ale_skip;
    logic program_fetch_strobe_skip;
    logic ale_en;
    logic ale_nxt;
    logic program_fetch_strobe_n_nxt;
    logic wr_n_nxt;
    logic rd_n_nxt;
    logic ale_oe_n_nxt;

    assign in_data = (cyc_r != ems_pkg::EMS_FETCH);
    assign ale_slot = (phase_r >= `EMS_ALE_A_START && phase_r <= `EMS_ALE_A_END) ||
                      (phase_r >= `EMS_ALE_B_START && phase_r <= `EMS_ALE_B_END); // [RQ6]
    assign program_fetch_strobe_slot = (phase_r >= `EMS_PROGRAM_FETCH_STROBE_A_START && phase_r <= `EMS_PROGRAM_FETCH_STROBE_A_END) ||
                       (phase_r >= `EMS_PROGRAM_FETCH_STROBE_B_START && phase_r <= `EMS_PROGRAM_FETCH_STROBE_B_END); // [RQ10]
    assign xd_slot = ((cyc_r == ems_pkg::EMS_DATA1) && phase_r >= `EMS_XD1_START) ||
                     ((cyc_r == ems_pkg::EMS_DATA2) && phase_r <= `EMS_XD2_END);
    // Data address is latched by the second strobe of the first cycle
    assign ale_skip = (cyc_r == ems_pkg::EMS_DATA2) && (phase_r <= `EMS_ALE_A_END); // [RQ7]
    // Strobe slots that would overlap the data strobe are withheld
    assign program_fetch_strobe_skip = ((cyc_r == ems_pkg::EMS_DATA1) && phase_r >= `EMS_PROGRAM_FETCH_STROBE_B_START) ||
                       ((cyc_r == ems_pkg::EMS_DATA2) && phase_r <= `EMS_PROGRAM_FETCH_STROBE_A_END); // [RQ11]
    assign ale_en = !ale_dis || ext_exec_o || in_data || code_move_instr_i; // [RQ8] [RQ9]
    assign ale_nxt = ale_en && ale_slot && !ale_skip && !core_rst_o; // [RQ5]
    assign ale_oe_n_nxt = !ale_en; // [RQ8]
    assign program_fetch_strobe_n_nxt = !(ext_exec_o && program_fetch_strobe_slot && !program_fetch_strobe_skip && !core_rst_o); // [RQ10]
    assign wr_n_nxt = !(xd_slot && xd_we_r && !core_rst_o); // [RQ15]
    assign rd_n_nxt = !(xd_slot && !xd_we_r && !core_rst_o); // [RQ16]

    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            ale_o <= 1'b0;
            ale_oe_n_o <= 1'b0;
            program_fetch_strobe_n_o <= 1'b1;
            port_three_pin_six_o <= 1'b1;
            port_three_pin_seven_o <= 1'b1;
        end else begin
            ale_o <= ale_nxt;
            ale_oe_n_o <= ale_oe_n_nxt;
            program_fetch_strobe_n_o <= program_fetch_strobe_n_nxt;
            port_three_pin_six_o <= wr_n_nxt;
            port_three_pin_seven_o <= rd_n_nxt;
        end
    end

    // Reset pin: input qualification and watchdog reset-out
    logic rin_zero;
    logic rout_zero;
    logic rout_busy_r;
    logic rout_drive_r;
    logic wait_low_r;
    logic rto_start;
    logic ext_rst;
    logic core_rst_nxt;

    // Count machine cycle ends while the pin is seen high
    ems_down_counter #(.W(8)) u_rin_cnt (
        .clk_i(ref_clk_i),
        .rst_i(sys_rst_i),
        .load_i(!rst_pin_s || rout_busy_r || wait_low_r),
        .load_val_i(`EMS_RST_IN_MC),
        .dec_i(mc_end),
        .zero_o(rin_zero)
    );
    assign ext_rst = rst_pin_s && rin_zero; // [RQ1]

    assign rto_start = wdt_timeout_i && !rout_busy_r && !wait_low_r && !core_rst_o;

    // The registered pin enable adds one clock, so the count starts one short
    ems_down_counter #(.W(8)) u_rout_cnt (
        .clk_i(ref_clk_i),
        .rst_i(sys_rst_i),
        .load_i(rto_start),
        .load_val_i(`EMS_RST_OUT_OSC - 8'h01),
        .dec_i(osc_en),
        .zero_o(rout_zero)
    );

    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            rout_busy_r <= 1'b0;
            rout_drive_r <= 1'b0;
            wait_low_r <= 1'b0;
        end else if (rto_start) begin
            rout_busy_r <= 1'b1;
            rout_drive_r <= !rto_dis; // [RQ3]
        end else if (rout_busy_r && rout_zero) begin
            rout_busy_r <= 1'b0; // [RQ2]
            rout_drive_r <= 1'b0;
            wait_low_r <= 1'b1;
        end else if (wait_low_r && !rst_pin_s) begin
            wait_low_r <= 1'b0; // [RQ18]
        end
    end

    assign rst_pin_o = rout_drive_r; // [RQ2]
    assign core_rst_nxt = ext_rst || rout_busy_r || wait_low_r || rto_start; // [RQ18]

    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            rst_pin_oe_n_o <= 1'b1;
            core_rst_o <= 1'b1;
        end else begin
            rst_pin_oe_n_o <= !(rto_start ? !rto_dis : (rout_drive_r && !rout_zero)); // [RQ3]
            core_rst_o <= core_rst_nxt;
        end
    end

    assign status_w = {27'h000_0000, in_data, !ea_n_eff, core_rst_o, rout_busy_r, ext_exec_o};
endmodule // ems_strobe_ctrl
`default_nettype wire

// File: ems_strobe_asserts.sv
// Purpose: Concurrent checks on the strobe and reset pins
// Assumes: OSC_DIV is 1, so one oscillator period is one clock
// Notes: Bound to ems_strobe_ctrl below
`timescale 1ns/100ps
`default_nettype none
module ems_strobe_asserts (
    input wire logic ref_clk_i, // Clock
    input wire logic sys_rst_i, // Reset
    input wire logic ale_o, // Latch strobe
    input wire logic ale_oe_n_o, // Latch strobe enable
    input wire logic program_fetch_strobe_n_o, // Fetch strobe
    input wire logic port_three_pin_six_o, // Write strobe
    input wire logic port_three_pin_seven_o, // Read strobe
    input wire logic rst_pin_o, // Reset pin value
    input wire logic rst_pin_oe_n_o, // Reset pin enable
    input wire logic core_rst_o, // Internal reset
    input wire logic ext_exec_o, // External execution
    input wire logic xdata_done_o // Data move done
);
    logic [7:0] drive_cnt_r;
    always_ff @(posedge ref_clk_i) begin
        drive_cnt_r <= (sys_rst_i || rst_pin_oe_n_o) ? 8'h00 : drive_cnt_r + 8'h01;
    end
    default clocking cb @(posedge ref_clk_i); endclocking
    // A core reset restarts the phase and may cut a strobe short
    default disable iff (sys_rst_i || core_rst_o);
    a_ale_width: assert property ($rose(ale_o) |=> (ale_o || ale_oe_n_o) ##1 !ale_o)
        else $error("latch strobe width wrong");
    a_ale_gap: assert property ($fell(ale_o) |-> !ale_o [*4])
        else $error("latch strobe gap too short");
    a_ale_release: assert property (ale_oe_n_o |-> !ale_o)
        else $error("released latch strobe not low");
    a_program_fetch_strobe_width: assert property ($fell(program_fetch_strobe_n_o)
        |-> !program_fetch_strobe_n_o [*3] ##1 program_fetch_strobe_n_o)
        else $error("fetch strobe width wrong");
    a_program_fetch_strobe_int: assert property (!$past(ext_exec_o) |-> program_fetch_strobe_n_o)
        else $error("fetch strobe during internal execution");
    a_wr_len: assert property ($fell(port_three_pin_six_o)
        |-> !port_three_pin_six_o [*8] ##1 port_three_pin_six_o)
        else $error("write strobe length wrong");
    a_rd_len: assert property ($fell(port_three_pin_seven_o)
        |-> !port_three_pin_seven_o [*8] ##1 port_three_pin_seven_o)
        else $error("read strobe length wrong");
    a_rto_len: assert property (disable iff (sys_rst_i) $rose(rst_pin_oe_n_o) |-> drive_cnt_r == 8'h62)
        else $error("reset-out pulse length wrong");
    a_rto_core: assert property (disable iff (sys_rst_i) !rst_pin_oe_n_o |-> rst_pin_o && core_rst_o)
        else $error("reset-out without drive high or core reset");
    c_ale: cover property ($rose(ale_o));
    c_rd: cover property ($fell(port_three_pin_seven_o));
    c_done: cover property (xdata_done_o);
    c_rto: cover property (disable iff (sys_rst_i) $fell(rst_pin_oe_n_o));
endmodule // ems_strobe_asserts
bind ems_strobe_ctrl ems_strobe_asserts u_asserts (.ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i),
    .ale_o(ale_o), .ale_oe_n_o(ale_oe_n_o), .program_fetch_strobe_n_o(program_fetch_strobe_n_o),
    .port_three_pin_six_o(port_three_pin_six_o), .port_three_pin_seven_o(port_three_pin_seven_o),
    .rst_pin_o(rst_pin_o), .rst_pin_oe_n_o(rst_pin_oe_n_o), .core_rst_o(core_rst_o),
    .ext_exec_o(ext_exec_o), .xdata_done_o(xdata_done_o));
`default_nettype wire

// File: ems_ext_mem_model.sv
// Purpose: External memory, address latch and board pins seen by the device
// Assumes: Reset pin has a board pull-down, latch strobe a weak pull-up
// Notes: Counts strobe events between clears for the bench
`timescale 1ns/100ps
`default_nettype none
module ems_ext_mem_model (
    input wire logic clk_i, // Clock
    input wire logic clr_i, // Clear counts
    input wire logic ale_i, // Latch strobe
    input wire logic ale_oe_n_i, // Latch enable
    input wire logic program_fetch_strobe_n_i, // Fetch strobe
    input wire logic wr_n_i, // Write strobe
    input wire logic rd_n_i, // Read strobe
    input wire logic rst_drv_i, // Reset drive
    input wire logic rst_oe_n_i, // Reset enable
    input wire logic ext_rst_i, // Board reset source
    output logic rst_pin_o, // Reset pin level
    output logic ale_pin_o, // Latch pin level
    output logic [7:0] ale_cnt_o, // Latch pulses
    output logic [7:0] program_fetch_strobe_cnt_o, // Fetch reads
    output logic [7:0] wr_lo_o, // Write low cycles
    output logic [7:0] rd_lo_o // Read low cycles
);
    logic ale_d_r;
    logic program_fetch_strobe_d_r;
    assign rst_pin_o = (!rst_oe_n_i && rst_drv_i) || ext_rst_i;
    assign ale_pin_o = ale_oe_n_i ? 1'b1 : ale_i;
    always_ff @(posedge clk_i) begin
        ale_d_r <= ale_pin_o;
        program_fetch_strobe_d_r <= program_fetch_strobe_n_i;
        if (clr_i) begin
            ale_cnt_o <= 8'h00;
            program_fetch_strobe_cnt_o <= 8'h00;
            wr_lo_o <= 8'h00;
            rd_lo_o <= 8'h00;
        end else begin
            ale_cnt_o <= ale_cnt_o + 8'(ale_pin_o && !ale_d_r);
            program_fetch_strobe_cnt_o <= program_fetch_strobe_cnt_o + 8'(!program_fetch_strobe_n_i && program_fetch_strobe_d_r);
            wr_lo_o <= wr_lo_o + 8'(!wr_n_i);
            rd_lo_o <= rd_lo_o + 8'(!rd_n_i);
        end
    end
endmodule // ems_ext_mem_model
`default_nettype wire

// File: tb.sv
// Purpose: Self-checking bench for the strobe and reset pin block
// Assumes: OSC_DIV 1, so a machine cycle is 12 clocks
// Notes: Reads are checked by a monitor against queued expectations
`timescale 1ns/100ps
`default_nettype none
`define EMS_CHK(g, e) begin checked++; if ((g) !== (e)) begin n_errors++; $display("[FAIL] %0t got %0h exp %0h", $time, (g), (e)); end end
module tb;
    logic ref_clk_i = 1'b0, sys_rst_i = 1'b1, avs_read_i = 1'b0, avs_write_i = 1'b0;
    logic [11:0] avs_address_i = 12'h000;
    logic [31:0] avs_writedata_i = 32'h0, avs_readdata_o, exp_v, lfsr_r = 32'h8585725B;
    logic [15:0] fetch_addr_i = 16'h0100;
    logic code_move_instr_i = 1'b0, xdata_req_i = 1'b0, xdata_we_i = 1'b0, wdt_timeout_i = 1'b0;
    logic lock_bit1_i = 1'b0, external_fetch_select_n_i = 1'b1, ext_rst = 1'b0, clr = 1'b1;
    logic avs_waitrequest_o, xdata_done_o, rst_pin, rst_pin_o, rst_pin_oe_n_o, ale_o, ale_oe_n_o;
    logic program_fetch_strobe_n_o, port_three_pin_six_o, port_three_pin_seven_o;
    logic ext_exec_o, core_rst_o, ale_pin;
    logic [7:0] ale_cnt, program_fetch_strobe_cnt, wr_lo, rd_lo;
    logic [31:0] exp_q[$];
    int n_errors = 0, checked = 0;
    always #2.5 ref_clk_i = ~ref_clk_i;
    ems_strobe_ctrl DUT (.ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i),
        .avs_address_i(avs_address_i), .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
        .avs_writedata_i(avs_writedata_i), .avs_byteenable_i(4'hF),
        .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
        .fetch_addr_i(fetch_addr_i), .code_move_instr_i(code_move_instr_i),
        .xdata_req_i(xdata_req_i), .xdata_we_i(xdata_we_i), .xdata_done_o(xdata_done_o),
        .wdt_timeout_i(wdt_timeout_i), .lock_bit1_i(lock_bit1_i),
        .external_fetch_select_n_i(external_fetch_select_n_i), .rst_pin_i(rst_pin),
        .rst_pin_o(rst_pin_o), .rst_pin_oe_n_o(rst_pin_oe_n_o), .ale_o(ale_o),
        .ale_oe_n_o(ale_oe_n_o), .program_fetch_strobe_n_o(program_fetch_strobe_n_o),
        .port_three_pin_six_o(port_three_pin_six_o),
        .port_three_pin_seven_o(port_three_pin_seven_o), .ext_exec_o(ext_exec_o),
        .core_rst_o(core_rst_o));
    ems_ext_mem_model u_mem (.clk_i(ref_clk_i), .clr_i(clr), .ale_i(ale_o), .ale_oe_n_i(ale_oe_n_o),
        .program_fetch_strobe_n_i(program_fetch_strobe_n_o), .wr_n_i(port_three_pin_six_o),
        .rd_n_i(port_three_pin_seven_o), .rst_drv_i(rst_pin_o), .rst_oe_n_i(rst_pin_oe_n_o),
        .ext_rst_i(ext_rst), .rst_pin_o(rst_pin), .ale_pin_o(ale_pin), .ale_cnt_o(ale_cnt),
        .program_fetch_strobe_cnt_o(program_fetch_strobe_cnt), .wr_lo_o(wr_lo), .rd_lo_o(rd_lo));
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic summarize;
        if (n_errors == 0 && checked > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    // Holds the request until waitrequest is sampled low, then lets an edge pass
    task automatic bus(input logic r, input logic [11:0] a, input logic [31:0] d);
        avs_address_i <= a;
        avs_writedata_i <= d;
        avs_read_i <= r;
        avs_write_i <= !r;
        @(posedge ref_clk_i);
        while (avs_waitrequest_o !== 1'b0) @(posedge ref_clk_i);
        avs_read_i <= 1'b0;
        avs_write_i <= 1'b0;
        @(posedge ref_clk_i);
    endtask
    task automatic rdx(input logic [11:0] a, input logic [31:0] e);
        exp_q.push_back(e);
        bus(1'b1, a, 32'h0);
    endtask
    always @(posedge ref_clk_i) begin
        if (avs_read_i === 1'b1 && avs_waitrequest_o === 1'b0) begin
            exp_v = exp_q.pop_front();
            `EMS_CHK(avs_readdata_o, exp_v)
        end
    end
    task automatic rst(input logic sn, input logic [15:0] fa, input logic cm, input logic lk);
        sys_rst_i <= 1'b1;
        external_fetch_select_n_i <= sn;
        fetch_addr_i <= fa;
        code_move_instr_i <= cm;
        lock_bit1_i <= lk;
        repeat (3) @(posedge ref_clk_i);
        sys_rst_i <= 1'b0;
        @(posedge ref_clk_i);
    endtask
    // Counts strobe events over 120 clocks, optionally with one data move inside
    task automatic win(input logic x, we, input logic [7:0] ea, ep, er, ew);
        int k;
        clr <= 1'b1;
        @(posedge ref_clk_i);
        clr <= 1'b0;
        k = 0;
        if (x) begin
            xdata_we_i <= we;
            xdata_req_i <= 1'b1;
            while (xdata_done_o !== 1'b1 && k < 60) begin
                @(posedge ref_clk_i);
                k++;
            end
            xdata_req_i <= 1'b0;
        end
        repeat (121 - k) @(posedge ref_clk_i);
        `EMS_CHK(ale_cnt, ea)
        `EMS_CHK(program_fetch_strobe_cnt, ep)
        `EMS_CHK(rd_lo, er)
        `EMS_CHK(wr_lo, ew)
    endtask
    task automatic wdt(input int ed);
        int k;
        int kc;
        wdt_timeout_i <= 1'b1;
        @(posedge ref_clk_i);
        wdt_timeout_i <= 1'b0;
        k = 0;
        kc = 0;
        repeat (150) begin
            @(posedge ref_clk_i);
            k += int'(rst_pin_oe_n_o === 1'b0);
            kc += int'(core_rst_o === 1'b1);
        end
        `EMS_CHK(k, ed)
        `EMS_CHK(kc > 97, 1'b1)
        `EMS_CHK(core_rst_o, 1'b0)
    endtask
    initial begin
        repeat (30000) @(posedge ref_clk_i);
        n_errors++;
        summarize();
    end
    initial begin
        repeat (2) @(posedge ref_clk_i);
        sys_rst_i <= 1'b0;
        @(posedge ref_clk_i);
        rdx(12'h238, 32'h0);
        rdx(12'h240, 32'h0);
        lfsr_r = lfsr(lfsr_r);
        bus(1'b0, 12'h23C, lfsr_r);
        rdx(12'h23C, 32'h0);
        bus(1'b0, 12'h238, lfsr_r);
        rdx(12'h238, {24'h0, lfsr_r[7:0]});
        bus(1'b0, 12'h238, 32'h0);
        win(1'b0, 1'b0, 8'd20, 8'd0, 8'd0, 8'd0);
        win(1'b1, 1'b1, 8'd19, 8'd0, 8'd0, 8'd8);
        lfsr_r = lfsr(lfsr_r);
        rst(1'b0, lfsr_r[15:0], 1'b0, 1'b0);
        rdx(12'h240, 32'h9);
        win(1'b0, 1'b0, 8'd20, 8'd20, 8'd0, 8'd0);
        win(1'b1, 1'b0, 8'd19, 8'd18, 8'd8, 8'd0);
        rst(1'b1, 16'h2000, 1'b0, 1'b0);
        win(1'b0, 1'b0, 8'd20, 8'd20, 8'd0, 8'd0);
        rst(1'b1, 16'h1FFF, 1'b0, 1'b0);
        bus(1'b0, 12'h238, 32'h1);
        win(1'b0, 1'b0, 8'd0, 8'd0, 8'd0, 8'd0);
        rst(1'b1, 16'h1FFF, 1'b1, 1'b0);
        bus(1'b0, 12'h238, 32'h1);
        win(1'b0, 1'b0, 8'd20, 8'd0, 8'd0, 8'd0);
        rst(1'b0, 16'h1FFF, 1'b0, 1'b0);
        bus(1'b0, 12'h238, 32'h1);
        win(1'b0, 1'b0, 8'd20, 8'd20, 8'd0, 8'd0);
        rst(1'b1, 16'h0100, 1'b0, 1'b0);
        wdt(98);
        rdx(12'h238, 32'h0);
        bus(1'b0, 12'h238, 32'h8);
        wdt(0);
        rst(1'b1, 16'h0100, 1'b0, 1'b1);
        ext_rst <= 1'b1;
        repeat (6) @(posedge ref_clk_i);
        `EMS_CHK(core_rst_o, 1'b0)
        `EMS_CHK(ext_exec_o, 1'b0)
        ext_rst <= 1'b0;
        repeat (6) @(posedge ref_clk_i);
        ext_rst <= 1'b1;
        external_fetch_select_n_i <= 1'b0;
        repeat (30) @(posedge ref_clk_i);
        `EMS_CHK(core_rst_o, 1'b1)
        ext_rst <= 1'b0;
        repeat (6) @(posedge ref_clk_i);
        `EMS_CHK(core_rst_o, 1'b0)
        external_fetch_select_n_i <= 1'b1;
        repeat (5) @(posedge ref_clk_i);
        `EMS_CHK(ext_exec_o, 1'b1)
        summarize();
    end
endmodule // tb
`default_nettype wire
